// *** hw/dtd_track_decoder.sv ***
// Drum track address decoder: maps three-character addresses to track spans.
// Assumes execution and plugboard sequencing logic share clk and drive
// requests as levels sampled on the same edge; answers follow one edge later.
`timescale 1ns/1ns
`include "dtd_params.svh"
module dtd_track_decoder
  import dtd_pkg::*;
#(
  parameter int STEP_W = 7,
  parameter int TRACK_CHARS = `DTD_TRACK_CHARS,
  parameter int MAX_FIELDS = `DTD_MAX_FIELDS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic [`DTD_AW-1:0] req_addr,
  input wire logic req_dest,
  input wire logic req_from_plug,
  input wire logic req_forward,
  input wire logic [1:0] req_fwd_slot,
  input wire logic io_unit_assigned,
  input wire logic [3:0] io_demand_unit,
  input wire logic seq_start,
  input wire logic [`DTD_AW-1:0] seq_addr_u,
  input wire logic [`DTD_AW-1:0] seq_addr_v,
  input wire logic [`DTD_AW-1:0] seq_addr_w,
  input wire logic [STEP_W-1:0] seq_step,
  input wire logic seq_end,
  input wire logic pat_wr_valid,
  input wire logic [`DTD_CHAR_BITS-1:0] pat_wr_char,
  output logic pat_wr_ready,
  output logic resp_valid_r,
  output logic resp_grant_r,
  output dtd_deny_t resp_deny_r,
  output dtd_area_t resp_area_r,
  output logic [6:0] resp_track_r,
  output logic [6:0] resp_start_r,
  output logic [6:0] resp_len_r,
  output logic plug_active_r,
  output logic [STEP_W-1:0] plug_entry_step_r,
  output logic [5:0] field_count_r,
  output logic field_overflow_r
);

  localparam logic [6:0] TRACK_LEN = 7'(TRACK_CHARS);
  localparam logic [6:0] WORD_LEN = 7'(`DTD_WORD_CHARS);
  localparam logic [4:0] LAST_WORD = 5'(`DTD_WORDS - 1);
  localparam int INTER_WORDS =
    (int'(`DTD_INTER_LAST) - int'(`DTD_INTER_FIRST) + 1) * `DTD_WORDS;

  // Geometry the decoder can serve
  generate
    if (TRACK_CHARS != `DTD_WORD_CHARS * `DTD_WORDS || TRACK_CHARS > 127) begin : g_bad_track
      $error("Track length must be ten words and fit seven bits");
    end
    if (MAX_FIELDS > `DTD_MAX_FIELDS || MAX_FIELDS < 1) begin : g_bad_fields
      $error("Field limit outside the letter range");
    end
    if (INTER_WORDS < `DTD_PROGRAM_WORDS) begin : g_bad_program
      $error("Intermediate area too small for the stored program");
    end
  endgenerate

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Pattern track storage and load sequencer
  logic [`DTD_CHAR_BITS-1:0] pat_mem_r [TRACK_CHARS];
  logic [TRACK_CHARS-1:0] pat_marks;
  logic [6:0] pat_idx_r;
  dtd_pat_state_t pat_state_r;
  logic [`DTD_AW-1:0] fwd_r [3];

  // Decode signals
  logic [`DTD_AW-1:0] eff_addr;
  logic [3:0] a_tens;
  logic [3:0] a_units;
  dtd_lo_kind_t a_kind;
  logic [4:0] a_val;
  logic [6:0] trk;
  logic [4:0] fld_idx;
  logic letter_ok;
  logic fld_hit;
  logic [6:0] fld_start;
  logic [6:0] fld_len;
  logic [6:0] mark_count;
  dtd_area_t area_nxt;
  dtd_deny_t deny_nxt;
  logic [6:0] start_nxt;
  logic [6:0] len_nxt;
  logic pat_open;

  always_comb begin
    for (int i = 0; i < TRACK_CHARS; i++) begin
      pat_marks[i] = pat_mem_r[i][`DTD_PARITY_BIT];
    end
  end

  assign pat_wr_ready = (pat_state_r == DTD_PAT_LOAD);

  // Forwarded address selection
  always_comb begin
    if (req_forward) begin
      case (req_fwd_slot)
        2'b00: eff_addr = fwd_r[0];
        2'b01: eff_addr = fwd_r[1];
        2'b10: eff_addr = fwd_r[2];
        default: eff_addr = '1;
      endcase
    end else begin
      eff_addr = req_addr;
    end
  end

  assign a_tens = eff_addr[`DTD_A_TENS];
  assign a_units = eff_addr[`DTD_A_UNITS];
  assign a_kind = dtd_lo_kind_t'(eff_addr[`DTD_A_KIND]);
  assign a_val = eff_addr[`DTD_A_VAL];
  assign trk = 7'({a_tens, 3'b000}) + 7'({a_tens, 1'b0}) + 7'(a_units);

  // Letter to field number, skipping I and O
  assign letter_ok = a_val <= `DTD_LETTER_V && a_val != `DTD_LETTER_I
                     && a_val != `DTD_LETTER_O;
  assign fld_idx = a_val - 5'(a_val > `DTD_LETTER_I) - 5'(a_val > `DTD_LETTER_O);

  dtd_field_locator #(
    .CHARS(TRACK_CHARS)
  ) u_locator (
    .marks(pat_marks),
    .field_idx(fld_idx),
    .hit(fld_hit),
    .start(fld_start),
    .len(fld_len),
    .mark_count(mark_count)
  );

  // Area, span and access decision
  always_comb begin
    area_nxt = DTD_AREA_NONE;
    deny_nxt = DTD_DENY_NONE;
    start_nxt = 7'h00;
    len_nxt = 7'h00;
    pat_open = 1'b0;
    if (a_tens > 4'h9 || a_units > 4'h9) begin
      area_nxt = DTD_AREA_NONE;
    end else if (trk <= `DTD_IO_LAST) begin
      area_nxt = DTD_AREA_IO;
    end else if (trk == `DTD_FACT_ONE || trk == `DTD_FACT_TWO) begin
      area_nxt = DTD_AREA_FACT;
    end else if (trk >= `DTD_INTER_FIRST && trk <= `DTD_INTER_LAST) begin
      area_nxt = DTD_AREA_INTER;
    end else if (trk == `DTD_SINGLE_TRACK && a_kind == DTD_LO_FIELD
                 && a_val == `DTD_LETTER_W) begin
      area_nxt = DTD_AREA_PAT;
    end
    if (area_nxt == DTD_AREA_NONE) begin
      deny_nxt = DTD_DENY_ADDR;
    end else if (area_nxt == DTD_AREA_PAT) begin
      start_nxt = 7'h00;
      len_nxt = TRACK_LEN;
      if (!req_dest || pat_state_r == DTD_PAT_LOAD) begin
        deny_nxt = DTD_DENY_DIR;
      end else begin
        pat_open = 1'b1;
      end
    end else begin
      case (a_kind)
        DTD_LO_WORD: begin
          // Word 9 is the first group past the head
          if (a_val > LAST_WORD) begin
            deny_nxt = DTD_DENY_ADDR;
          end else begin
            start_nxt = 7'(LAST_WORD - a_val) * WORD_LEN;
            len_nxt = WORD_LEN;
          end
        end
        DTD_LO_FIELD: begin
          // Pattern governs fields of tracks 00-09 and 11-97
          if (!letter_ok || !fld_hit) begin
            deny_nxt = DTD_DENY_FIELD;
          end else begin
            start_nxt = fld_start;
            len_nxt = fld_len;
          end
        end
        DTD_LO_BLOCK: begin
          start_nxt = 7'h00;
          len_nxt = TRACK_LEN;
        end
        default: deny_nxt = DTD_DENY_ADDR;
      endcase
      if (deny_nxt == DTD_DENY_NONE && req_from_plug) begin
        if (req_forward) begin
          if (!plug_active_r || req_fwd_slot == 2'b11) begin
            deny_nxt = DTD_DENY_ROUTE;
          end
        end else if (area_nxt == DTD_AREA_INTER) begin
          deny_nxt = DTD_DENY_ROUTE;
        end else if (area_nxt == DTD_AREA_IO
                     && !(io_unit_assigned && io_demand_unit == trk[3:0])) begin
          deny_nxt = DTD_DENY_DEMAND;
        end
      end
    end
  end

  // Response registers; stored instructions face no gating
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid_r <= 1'b0;
      resp_grant_r <= 1'b0;
      resp_deny_r <= DTD_DENY_NONE;
      resp_area_r <= DTD_AREA_NONE;
      resp_track_r <= 7'h00;
      resp_start_r <= 7'h00;
      resp_len_r <= 7'h00;
    end else begin
      resp_valid_r <= req_valid;
      if (req_valid) begin
        resp_grant_r <= (deny_nxt == DTD_DENY_NONE);
        resp_deny_r <= deny_nxt;
        resp_area_r <= area_nxt;
        resp_track_r <= trk;
        resp_start_r <= start_nxt;
        resp_len_r <= len_nxt;
      end else begin
        resp_grant_r <= 1'b0;
      end
    end
  end

  // Plugboard sequence: forwarded addresses and entry step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      plug_active_r <= 1'b0;
      plug_entry_step_r <= '0;
      fwd_r[0] <= '0;
      fwd_r[1] <= '0;
      fwd_r[2] <= '0;
    end else if (seq_start) begin
      plug_active_r <= 1'b1;
      plug_entry_step_r <= seq_step;
      fwd_r[0] <= seq_addr_u;
      fwd_r[1] <= seq_addr_v;
      fwd_r[2] <= seq_addr_w;
    end else if (seq_end) begin
      plug_active_r <= 1'b0;
    end
  end

  // Pattern load sequencer: opened by a granted 99W destination
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_state_r <= DTD_PAT_IDLE;
      pat_idx_r <= 7'h00;
    end else begin
      case (pat_state_r)
        DTD_PAT_IDLE: begin
          if (req_valid && pat_open) begin
            pat_state_r <= DTD_PAT_LOAD;
            pat_idx_r <= 7'h00;
          end
        end
        DTD_PAT_LOAD: begin
          if (pat_wr_valid) begin
            if (pat_idx_r == TRACK_LEN - 7'h01) begin
              pat_state_r <= DTD_PAT_IDLE;
              pat_idx_r <= 7'h00;
            end else begin
              pat_idx_r <= pat_idx_r + 7'h01;
            end
          end
        end
        default: pat_state_r <= DTD_PAT_IDLE;
      endcase
    end
  end

  // Whole characters are kept; only their parity bits steer fields
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < TRACK_CHARS; i++) begin
        pat_mem_r[i] <= '0;
      end
    end else if (pat_wr_valid && pat_wr_ready) begin
      pat_mem_r[pat_idx_r] <= pat_wr_char;
    end
  end

  // Count of defined fields; more than the letter range is flagged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      field_count_r <= 6'h00;
      field_overflow_r <= 1'b0;
    end else begin
      field_count_r <= 6'(mark_count);
      field_overflow_r <= (mark_count > 7'(MAX_FIELDS));
    end
  end

  a_factor_open: assert property (
    req_valid && !req_forward && a_tens == 4'h1 && (a_units == 4'h1 || a_units == 4'h2)
    && a_kind == DTD_LO_WORD && a_val <= 5'h09 |=> resp_grant_r && resp_area_r == DTD_AREA_FACT
  ) else $error("factor track word refused");

  a_pattern_dest_only: assert property (
    req_valid && !req_forward && trk == 7'h63 && a_kind == DTD_LO_FIELD && a_val == 5'h16
    && !req_dest |=> !resp_grant_r && resp_deny_r == DTD_DENY_DIR
  ) else $error("pattern track granted as source");

  a_pattern_store: assert property (
    pat_wr_valid && pat_wr_ready |=> pat_mem_r[$past(pat_idx_r)] == $past(pat_wr_char)
  ) else $error("pattern character not stored whole");

  a_letter_skip: assert property (
    req_valid && a_kind == DTD_LO_FIELD && a_val == 5'h08 && trk <= 7'h61 && trk != 7'h0a
    && a_tens <= 4'h9 && a_units <= 4'h9 |=> resp_deny_r == DTD_DENY_FIELD
  ) else $error("letter I accepted as a field");

  a_word_span: assert property (
    req_valid && !req_from_plug && !req_forward && req_addr == {4'h0, 4'h3, 2'b00, 5'h02}
    |=> resp_grant_r && resp_track_r == 7'h03 && resp_start_r == 7'h54 && resp_len_r == 7'h0c
  ) else $error("word 2 of track 03 misplaced");

  a_block_whole: assert property (
    req_valid && !req_from_plug && !req_forward && a_kind == DTD_LO_BLOCK && trk <= 7'h61
    && a_tens <= 4'h9 && a_units <= 4'h9 && trk != 7'h0a
    |=> resp_grant_r && resp_start_r == 7'h00 && resp_len_r == 7'h78
  ) else $error("blockette not whole track");

  a_demand_gate: assert property (
    req_valid && req_from_plug && !req_forward && a_kind == DTD_LO_WORD && a_val <= 5'h09
    && a_tens == 4'h0 && a_units <= 4'h9 && !io_unit_assigned
    |=> !resp_grant_r && resp_deny_r == DTD_DENY_DEMAND
  ) else $error("I/O track reached without demand");

  a_inter_route: assert property (
    req_valid && req_from_plug && !req_forward && a_tens <= 4'h9 && a_units <= 4'h9
    && trk >= 7'h0d && trk <= 7'h61 && (a_kind == DTD_LO_BLOCK || a_kind == DTD_LO_WORD)
    && a_val <= 5'h09 |=> !resp_grant_r && resp_deny_r == DTD_DENY_ROUTE
  ) else $error("intermediate track reached directly");

  a_entry_step: assert property (
    seq_start |=> plug_active_r && plug_entry_step_r == $past(seq_step)
  ) else $error("plugboard entry step lost");

  c_factor_grant: cover property (resp_grant_r && resp_area_r == DTD_AREA_FACT);
  c_forward_grant: cover property (
    req_valid && req_forward && plug_active_r ##1 resp_grant_r
  );
  c_pattern_done: cover property (
    pat_state_r == DTD_PAT_LOAD ##1 pat_state_r == DTD_PAT_IDLE
  );

endmodule : dtd_track_decoder

// *** pkg/dtd_params.svh ***
// Constants for the drum track address decoder.
// Assumes addresses arrive as packed {tens, units, low kind, low value} fields.
`ifndef DTD_PARAMS_SVH
`define DTD_PARAMS_SVH

// Packed three-character address layout
`define DTD_AW 15
`define DTD_A_TENS 14:11
`define DTD_A_UNITS 10:7
`define DTD_A_KIND 6:5
`define DTD_A_VAL 4:0

// Track codes
`define DTD_IO_LAST 7'h09
`define DTD_FACT_ONE 7'h0b
`define DTD_FACT_TWO 7'h0c
`define DTD_INTER_FIRST 7'h0d
`define DTD_INTER_LAST 7'h61
`define DTD_SINGLE_TRACK 7'h63

// Letter indices counted from A = 0
`define DTD_LETTER_I 5'h08
`define DTD_LETTER_O 5'h0e
`define DTD_LETTER_V 5'h15
`define DTD_LETTER_W 5'h16

// Drum geometry
`define DTD_TRACK_CHARS 120
`define DTD_WORD_CHARS 12
`define DTD_WORDS 10
`define DTD_MAX_FIELDS 20
`define DTD_PROGRAM_WORDS 850
`define DTD_CHAR_BITS 7
`define DTD_PARITY_BIT 6

`endif

// *** pkg/dtd_pkg.sv ***
// Types shared by the drum track address decoder files.
// Assumes dtd_params.svh supplies all numeric constants.
package dtd_pkg;

  typedef enum logic [1:0] {
    DTD_LO_WORD = 2'b00,
    DTD_LO_FIELD = 2'b01,
    DTD_LO_BLOCK = 2'b10
  } dtd_lo_kind_t;

  typedef enum logic [2:0] {
    DTD_AREA_NONE = 3'b000,
    DTD_AREA_IO = 3'b001,
    DTD_AREA_FACT = 3'b010,
    DTD_AREA_INTER = 3'b011,
    DTD_AREA_PAT = 3'b100
  } dtd_area_t;

  typedef enum logic [2:0] {
    DTD_DENY_NONE = 3'b000,
    DTD_DENY_ADDR = 3'b001,
    DTD_DENY_DIR = 3'b010,
    DTD_DENY_FIELD = 3'b011,
    DTD_DENY_DEMAND = 3'b100,
    DTD_DENY_ROUTE = 3'b101
  } dtd_deny_t;

  typedef enum logic {
    DTD_PAT_IDLE = 1'b0,
    DTD_PAT_LOAD = 1'b1
  } dtd_pat_state_t;

endpackage : dtd_pkg

// *** hw/dtd_field_locator.sv ***
// Finds start and length of one field from the end-of-field marks of a track.
// Assumes marks are indexed by character position, 0 first past the head.
`timescale 1ns/1ns
`include "dtd_params.svh"
module dtd_field_locator #(
  parameter int CHARS = `DTD_TRACK_CHARS
) (
  input wire logic [CHARS-1:0] marks,
  input wire logic [4:0] field_idx,
  output logic hit,
  output logic [6:0] start,
  output logic [6:0] len,
  output logic [6:0] mark_count
);
  logic [6:0] cnt;
  logic [6:0] beg;

  always_comb begin
    cnt = 7'h00;
    beg = 7'h00;
    hit = 1'b0;
    start = 7'h00;
    len = 7'h00;
    // Letters go in order to successive mark-terminated groups from char 0
    for (int i = 0; i < CHARS; i++) begin
      if (marks[i]) begin
        if (!hit && cnt == {2'b00, field_idx}) begin
          hit = 1'b1;
          start = beg;
          len = 7'(i + 1) - beg;
        end
        cnt = cnt + 7'h01;
        beg = 7'(i + 1);
      end
    end
    mark_count = cnt;
  end
endmodule : dtd_field_locator

// *** verif/dtd_seq_model.sv ***
// Far-side model of the sequencing logic: streams a field pattern into the decoder.
// Assumes a shared clk; drives on the falling edge and stalls every fifth cycle.
`timescale 1ns/1ns
module dtd_seq_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [6:0] fld_len,
  input wire logic pat_wr_ready,
  output logic pat_wr_valid,
  output logic [6:0] pat_wr_char,
  output logic done
);
  int pos;
  int tick;
  logic busy;
  // Every fld_len-th character ends a field; low bits vary so only bit 6 counts
  function automatic logic [6:0] pat_char(input int p, input int l);
    if ((p % l) == (l - 1)) return p[1] ? 7'h54 : 7'h45;
    return p[1] ? 7'h3f : 7'h07;
  endfunction : pat_char
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos <= 0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      pos <= 0;
      done <= 1'b0;
    end else if (busy && pat_wr_valid && pat_wr_ready) begin
      // Whole track of 120 characters, in track order
      if (pos == 119) begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      pos <= pos + 1;
    end
  end
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_wr_valid <= 1'b0;
      pat_wr_char <= 7'h00;
      tick <= 0;
    end else begin
      tick <= tick + 1;
      pat_wr_valid <= busy && ((tick % 5) != 4);
      // Idle line toggles between the last character and its complement
      pat_wr_char <= busy ? pat_char(pos, fld_len) : ~pat_wr_char;
    end
  end
endmodule : dtd_seq_model

// *** verif/test_dtd_track_decoder.sv ***
// Self-checking bench for the drum track address decoder.
// Assumes dtd_seq_model streams patterns; all other inputs come from here.
`timescale 1ns/1ns
module test_dtd_track_decoder;
  import dtd_pkg::*;
  logic clk = 0, rst_b = 0, req_valid = 0, req_dest = 0, req_from_plug = 0, req_forward = 0;
  logic [14:0] req_addr = 0, seq_addr_u = 0, seq_addr_v = 0, seq_addr_w = 0;
  logic [1:0] req_fwd_slot = 0;
  logic io_unit_assigned = 0, seq_start = 0, seq_end = 0, go = 0;
  logic [3:0] io_demand_unit = 0;
  logic [6:0] seq_step = 0, fld_len = 7'h06, pat_wr_char, resp_track_r, resp_start_r, resp_len_r;
  logic [6:0] plug_entry_step_r;
  logic pat_wr_valid, pat_wr_ready, resp_valid_r, resp_grant_r, plug_active_r, done;
  logic field_overflow_r;
  logic [5:0] field_count_r;
  dtd_deny_t resp_deny_r;
  dtd_area_t resp_area_r;
  int fail_count = 0, cmp_count = 0;
  always #20 clk = ~clk;
  dtd_track_decoder dtd_track_decoder_inst (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_addr(req_addr), .req_dest(req_dest), .req_from_plug(req_from_plug),
    .req_forward(req_forward), .req_fwd_slot(req_fwd_slot),
    .io_unit_assigned(io_unit_assigned), .io_demand_unit(io_demand_unit),
    .seq_start(seq_start), .seq_addr_u(seq_addr_u), .seq_addr_v(seq_addr_v),
    .seq_addr_w(seq_addr_w), .seq_step(seq_step), .seq_end(seq_end),
    .pat_wr_valid(pat_wr_valid), .pat_wr_char(pat_wr_char), .pat_wr_ready(pat_wr_ready),
    .resp_valid_r(resp_valid_r), .resp_grant_r(resp_grant_r), .resp_deny_r(resp_deny_r),
    .resp_area_r(resp_area_r), .resp_track_r(resp_track_r), .resp_start_r(resp_start_r),
    .resp_len_r(resp_len_r), .plug_active_r(plug_active_r),
    .plug_entry_step_r(plug_entry_step_r), .field_count_r(field_count_r),
    .field_overflow_r(field_overflow_r));
  dtd_seq_model dtd_seq_model_inst (.clk(clk), .rst_b(rst_b), .go(go), .fld_len(fld_len),
    .pat_wr_ready(pat_wr_ready), .pat_wr_valid(pat_wr_valid), .pat_wr_char(pat_wr_char),
    .done(done));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s seen %0h want %0h", $time, what, seen, exp);
    end
  endtask : chk
  function automatic logic [14:0] ad(input int t, input dtd_lo_kind_t k, input int v);
    return {4'(t / 10), 4'(t % 10), k, 5'(v)};
  endfunction : ad
  task automatic rq(input logic [14:0] a, input logic d, p, f, input logic [1:0] s);
    @(negedge clk);
    req_valid = 1;
    {req_addr, req_dest, req_from_plug, req_forward, req_fwd_slot} = {a, d, p, f, s};
    @(negedge clk);
    req_valid = 0;
    chk(resp_valid_r, 1, "answer");
  endtask : rq
  task automatic ok(input logic [14:0] a, input logic p, f, input logic [1:0] s,
                    input dtd_area_t ar, input int t, st, ln);
    rq(a, 0, p, f, s);
    chk(resp_grant_r, 1, "grant");
    chk(resp_area_r, ar, "area");
    chk(resp_track_r, 8'(t), "track");
    chk(resp_start_r, 8'(st), "start");
    chk(resp_len_r, 8'(ln), "len");
  endtask : ok
  task automatic no(input logic [14:0] a, input logic d, p, f, input dtd_deny_t dn);
    rq(a, d, p, f, 0);
    chk(resp_grant_r, 0, "grant");
    chk(resp_deny_r, dn, "deny");
  endtask : no
  function automatic dtd_area_t area_of(input int t);
    if (t <= 9) return DTD_AREA_IO;
    if (t <= 12) return DTD_AREA_FACT;
    return DTD_AREA_INTER;
  endfunction : area_of
  task automatic t_words;
    int tr[8] = '{3, 11, 87, 12, 13, 97, 0, 9};
    int wd[8] = '{2, 9, 0, 5, 9, 0, 9, 0};
    for (int i = 0; i < 8; i++) begin
      ok(ad(tr[i], DTD_LO_WORD, wd[i]), 0, 0, 0, area_of(tr[i]), tr[i], (9 - wd[i]) * 12,
         12);
    end
    ok(ad(1, DTD_LO_BLOCK, 0), 0, 0, 0, DTD_AREA_IO, 1, 0, 120);
    ok(ad(12, DTD_LO_BLOCK, 0), 0, 0, 0, DTD_AREA_FACT, 12, 0, 120);
    ok(ad(50, DTD_LO_BLOCK, 0), 0, 0, 0, DTD_AREA_INTER, 50, 0, 120);
    no(ad(10, DTD_LO_WORD, 0), 0, 0, 0, DTD_DENY_ADDR);
    no(ad(98, DTD_LO_WORD, 0), 0, 0, 0, DTD_DENY_ADDR);
    no(ad(5, DTD_LO_FIELD, 0), 0, 0, 0, DTD_DENY_FIELD);
    no(ad(99, DTD_LO_FIELD, 22), 0, 0, 0, DTD_DENY_DIR);
    $display("test words done");
  endtask : t_words
  task automatic t_load(input int len, input int cnt);
    fld_len = 7'(len);
    rq(ad(99, DTD_LO_FIELD, 22), 1, 0, 0, 0);
    chk(resp_grant_r, 1, "pattern grant");
    chk(resp_area_r, DTD_AREA_PAT, "pattern area");
    go = 1;
    chk(pat_wr_ready, 1, "ready");
    @(negedge clk);
    go = 0;
    no(ad(99, DTD_LO_FIELD, 22), 1, 0, 0, DTD_DENY_DIR);
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk(done, 1, "load done");
    chk(pat_wr_ready, 0, "ready after load");
    chk(field_count_r, 8'(cnt), "field count");
    chk(field_overflow_r, cnt > 20, "overflow");
    $display("test load %0d done", len);
  endtask : t_load
  task automatic t_fields;
    ok(ad(5, DTD_LO_FIELD, 0), 0, 0, 0, DTD_AREA_IO, 5, 0, 6);
    ok(ad(47, DTD_LO_FIELD, 21), 0, 0, 0, DTD_AREA_INTER, 47, 114, 6);
    ok(ad(11, DTD_LO_FIELD, 9), 0, 0, 0, DTD_AREA_FACT, 11, 48, 6);
    ok(ad(30, DTD_LO_FIELD, 15), 0, 0, 0, DTD_AREA_INTER, 30, 78, 6);
    no(ad(30, DTD_LO_FIELD, 8), 0, 0, 0, DTD_DENY_FIELD);
    ok(ad(3, DTD_LO_WORD, 2), 0, 0, 0, DTD_AREA_IO, 3, 84, 12);
    $display("test fields done");
  endtask : t_fields
  task automatic t_plug;
    @(negedge clk);
    io_unit_assigned = 1;
    io_demand_unit = 5;
    ok(ad(5, DTD_LO_WORD, 0), 1, 0, 0, DTD_AREA_IO, 5, 108, 12);
    ok(ad(12, DTD_LO_WORD, 9), 1, 0, 0, DTD_AREA_FACT, 12, 0, 12);
    io_demand_unit = 3;
    no(ad(5, DTD_LO_WORD, 0), 0, 1, 0, DTD_DENY_DEMAND);
    io_unit_assigned = 0;
    io_demand_unit = 5;
    no(ad(5, DTD_LO_WORD, 0), 0, 1, 0, DTD_DENY_DEMAND);
    no(ad(87, DTD_LO_WORD, 0), 0, 1, 0, DTD_DENY_ROUTE);
    no(0, 0, 1, 1, DTD_DENY_ROUTE);
    seq_addr_u = ad(5, DTD_LO_WORD, 0);
    seq_addr_v = ad(6, DTD_LO_WORD, 0);
    seq_addr_w = ad(87, DTD_LO_WORD, 0);
    seq_step = 7'h41;
    seq_start = 1;
    @(negedge clk);
    seq_start = 0;
    chk(plug_active_r, 1, "active");
    chk(plug_entry_step_r, 8'h41, "entry step");
    ok(0, 1, 1, 2, DTD_AREA_INTER, 87, 108, 12);
    ok(0, 1, 1, 0, DTD_AREA_IO, 5, 108, 12);
    ok(0, 1, 1, 1, DTD_AREA_IO, 6, 108, 12);
    rq(0, 0, 1, 1, 3);
    chk(resp_grant_r, 0, "slot 3 refused");
    seq_step = 7'h49;
    seq_start = 1;
    seq_end = 1;
    @(negedge clk);
    seq_start = 0;
    chk(plug_entry_step_r, 8'h49, "entry step");
    chk(plug_active_r, 1, "start wins over end");
    seq_end = 1;
    @(negedge clk);
    seq_end = 0;
    chk(plug_active_r, 0, "ended");
    no(0, 0, 1, 1, DTD_DENY_ROUTE);
    $display("test plug done");
  endtask : t_plug
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #800000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1;
    chk(resp_valid_r, 0, "reset valid");
    chk(pat_wr_ready, 0, "reset ready");
    chk(field_count_r, 0, "reset count");
    t_words();
    t_load(6, 20);
    t_fields();
    t_load(5, 24);
    ok(ad(47, DTD_LO_FIELD, 21), 0, 0, 0, DTD_AREA_INTER, 47, 95, 5);
    t_plug();
    report_and_stop();
  end
endmodule : test_dtd_track_decoder
